/* File: include/pfs_pkg.sv */
// constants, function indices and carrier types for the port 0 pin function select
// =============================================================================
// What this block does
// - low register: 2-bit field per pin 0-15
// - high register: 2-bit field per pin 16-31
// - gpio direction drives enable only in gpio
// - peripheral function sets pin direction automatically
// - debug ports chosen only by reset strap
// - pins 17-31 fields act only without debug
// - pin 2: i2c clock or timer0 capture0
// - pin 4: spi clock or timer0 capture1
// - pin 6: spi mosi or timer0 capture2
// - pin 10: uart1 rts or timer1 capture0
// - pin 11: uart1 cts or timer1 capture1
// - pin 17: timer1 capture2 on code 01
// - pin 18: timer1 capture3 on code 01
// =============================================================================
package pfs_pkg;

   // =========================================================================
   // bus map
   // =========================================================================
   localparam logic [31:0] PFS_ADR_LOW    = 32'he002c000; // pins 0..15
   localparam logic [31:0] PFS_ADR_HIGH   = 32'he002c004; // pins 16..31
   localparam logic [31:0] PFS_ADR_STATUS = 32'he002c008; // debug mode flag
   localparam logic [31:0] PFS_SEL_RESET  = 32'h00000000; // every pin gpio
   localparam int          PFS_DBG_BIT    = 0;            // status bit

   // =========================================================================
   // pin and field geometry
   // =========================================================================
   localparam int          PFS_PINS   = 32; // port width
   localparam int          PFS_FLD    = 2;  // bits per pin field
   localparam int          PFS_DBG_LO = 17; // first pin owned by debug
   localparam logic [1:0]  PFS_GPIO   = 2'h0;
   localparam logic [1:0]  PFS_ALT1   = 2'h1;
   localparam logic [1:0]  PFS_ALT2   = 2'h2;

   // =========================================================================
   // peripheral function indices, grouped by direction class
   // =========================================================================
   localparam int          PF_N  = 38; // index 0 means none
   localparam int          PF_FW = 6;
   localparam logic [5:0]  PF_NONE           = 6'h00;
   // peripheral decides direction
   localparam logic [5:0]  PF_I2C_SCL        = 6'h01;
   localparam logic [5:0]  PF_I2C_SDA        = 6'h02;
   localparam logic [5:0]  PF_SPI_SCK        = 6'h03;
   localparam logic [5:0]  PF_SPI_MISO       = 6'h04;
   localparam logic [5:0]  PF_SPI_MOSI       = 6'h05;
   localparam logic [5:0]  PF_SPI_SSEL       = 6'h06;
   // always inputs
   localparam logic [5:0]  PF_IN_FIRST       = 6'h07;
   localparam logic [5:0]  PF_UART0_RXD      = 6'h07;
   localparam logic [5:0]  PF_UART1_RXD      = 6'h08;
   localparam logic [5:0]  PF_UART1_CTS      = 6'h09;
   localparam logic [5:0]  PF_UART1_DSR      = 6'h0a;
   localparam logic [5:0]  PF_UART1_RI       = 6'h0b;
   localparam logic [5:0]  PF_EXTERNAL_INT_0 = 6'h0c;
   localparam logic [5:0]  PF_EXTERNAL_INT_1 = 6'h0d;
   localparam logic [5:0]  PF_EXTERNAL_INT_2 = 6'h0e;
   localparam logic [5:0]  PF_CAP0_0         = 6'h0f;
   localparam logic [5:0]  PF_CAP0_1         = 6'h10;
   localparam logic [5:0]  PF_CAP0_2         = 6'h11;
   localparam logic [5:0]  PF_CAP1_0         = 6'h12;
   localparam logic [5:0]  PF_CAP1_1         = 6'h13;
   localparam logic [5:0]  PF_CAP1_2         = 6'h14;
   localparam logic [5:0]  PF_CAP1_3         = 6'h15;
   // always outputs
   localparam logic [5:0]  PF_OUT_FIRST      = 6'h16;
   localparam logic [5:0]  PF_UART0_TXD      = 6'h16;
   localparam logic [5:0]  PF_UART1_TXD      = 6'h17;
   localparam logic [5:0]  PF_UART1_RTS      = 6'h18;
   localparam logic [5:0]  PF_UART1_DTR      = 6'h19;
   localparam logic [5:0]  PF_PWM_OUTPUT_1   = 6'h1a;
   localparam logic [5:0]  PF_PWM_OUTPUT_2   = 6'h1b;
   localparam logic [5:0]  PF_PWM_OUTPUT_3   = 6'h1c;
   localparam logic [5:0]  PF_PWM_OUTPUT_4   = 6'h1d;
   localparam logic [5:0]  PF_PWM_OUTPUT_5   = 6'h1e;
   localparam logic [5:0]  PF_PWM_OUTPUT_6   = 6'h1f;
   localparam logic [5:0]  PF_MAT0_0         = 6'h20;
   localparam logic [5:0]  PF_MAT0_1         = 6'h21;
   localparam logic [5:0]  PF_MAT0_2         = 6'h22;
   localparam logic [5:0]  PF_MAT1_1         = 6'h23;
   localparam logic [5:0]  PF_MAT1_2         = 6'h24;
   localparam logic [5:0]  PF_MAT1_3         = 6'h25;
   // level a peripheral input sees while no pin feeds it (idle high)
   localparam logic [PF_N-1:0] PF_IN_IDLE    = {PF_N{1'b1}};

   // =========================================================================
   // carriers between this block and the peripherals
   // =========================================================================
   typedef struct packed {
      logic [PF_N-1:0] value; // level each peripheral wants on its pin
      logic [PF_N-1:0] oe;    // enable, read only for bidirectional ones
   } pfs_drive_t;

   typedef struct packed {
      logic [PF_N-1:0] value; // synchronised pin level per function
   } pfs_sense_t;

endpackage : pfs_pkg

/* File: logic/pfs_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pfs_sync #(
   parameter int W = 1                    // number of bits
) (
   input  wire logic         clk_i,      // system clock
   input  wire logic         rst_i,      // synchronous reset, high
   input  wire logic [W-1:0] async_i,    // levels from pins
   output logic      [W-1:0] sync_o      // filtered, clock-aligned
);
   // =========================================================================
   // flop chain; stage one feeds only stage two
   // =========================================================================
   logic [W-1:0] st1;      // metastability catcher
   logic [W-1:0] st2;      // second stage
   logic [W-1:0] st3;      // third stage
   logic [W-1:0] next_out; // accepted level

   // a change is taken only once stages two and three agree; while reset is
   // held the output tracks stage three, so a strap can be read during reset
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (rst_i) begin
            next_out[i] = st3[i];
         end else begin
            next_out[i] = (st2[i] == st3[i]) ? st3[i] : sync_o[i];
         end
      end
   end

   // registers only; the chain has no reset so it keeps sampling in reset
   always_ff @(posedge clk_i) begin
      st1    <= async_i;
      st2    <= st1;
      st3    <= st2;
      sync_o <= next_out;
   end
endmodule : pfs_sync

/* File: logic/pfs_pin_mux.sv */
// port 0 pin function select: registers, pin multiplexer and debug takeover
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module pfs_pin_mux
   import pfs_pkg::*;
(
   input  wire logic                   clk_i,           // 200 MHz clock
   input  wire logic                   rst_i,           // sync reset, high
   // wishbone classic slave
   input  wire logic                   wb_cyc_i,        // cycle
   input  wire logic                   wb_stb_i,        // strobe
   input  wire logic                   wb_we_i,         // write
   input  wire logic [31:0]            wb_adr_i,        // byte address
   input  wire logic [31:0]            wb_dat_i,        // write data
   input  wire logic [3:0]             wb_sel_i,        // byte lanes
   output logic                        wb_ack_o,        // answer
   output logic      [31:0]            wb_dat_o,        // read data
   // pads
   input  wire logic [PFS_PINS-1:0]    pin_i,           // pad levels
   output logic      [PFS_PINS-1:0]    pin_out_o,       // pad drive level
   output logic      [PFS_PINS-1:0]    pin_oe_o,        // pad drive enable
   input  wire logic                   debug_select_i,  // debug strap pad
   // gpio block
   input  wire logic [PFS_PINS-1:0]    gpio_out_i,      // gpio data out
   input  wire logic [PFS_PINS-1:0]    gpio_direction_i, // 1 = output
   output logic      [PFS_PINS-1:0]    gpio_in_o,       // pin levels
   // peripherals
   input  wire pfs_drive_t             periph_drive_i,  // peripheral drive
   output pfs_sense_t                  periph_sense_o,  // peripheral inputs
   // debug and trace ports on pins 17..31
   input  wire logic [PFS_PINS-1:PFS_DBG_LO] debug_out_i, // debug drive
   input  wire logic [PFS_PINS-1:PFS_DBG_LO] debug_oe_i,  // debug enable
   output logic      [PFS_PINS-1:PFS_DBG_LO] debug_in_o,  // debug inputs
   output logic                        debug_mode_o     // strap latched
);
   // =========================================================================
   // state
   // =========================================================================
   logic [31:0]          sel_low;      // fields of pins 0..15
   logic [31:0]          sel_high;     // fields of pins 16..31
   logic [2*PFS_PINS-1:0] sel_all;     // both registers, pin 0 at the bottom
   logic [31:0]          next_low;     // next low fields
   logic [31:0]          next_high;    // next high fields
   logic                 next_ack;     // next answer
   logic [31:0]          next_dat;     // next read data
   logic                 next_dbg;     // next debug mode
   logic [PFS_PINS:0]    synced;       // pins plus strap, filtered
   logic [PFS_PINS-1:0]  pin_sync;     // filtered pin levels
   logic                 dbg_sync;     // filtered strap
   logic [PFS_PINS-1:0]  next_out;     // next pad levels
   logic [PFS_PINS-1:0]  next_oe;      // next pad enables
   pfs_sense_t           next_sense;   // next peripheral inputs

   assign pin_sync = synced[PFS_PINS-1:0];
   assign dbg_sync = synced[PFS_PINS];
   assign sel_all  = {sel_high, sel_low};

   // =========================================================================
   // helpers
   // =========================================================================
   // merge write data into a register by byte lane
   function automatic logic [31:0] pfs_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  lanes);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (lanes[b]) begin
            r[8*b +: 8] = wdat[8*b +: 8];
         end
      end
      return r;
   endfunction : pfs_merge

   // field code to peripheral index; reserved codes give none
   function automatic logic [PF_FW-1:0] pfs_route(input logic [4:0] pin,
                                                  input logic [1:0] code);
      logic [2*PF_FW-1:0] ab;   // {code 01 choice, code 10 choice}
      ab = {PF_NONE, PF_NONE};
      case (pin)
         5'h00: ab = {PF_UART0_TXD, PF_PWM_OUTPUT_1};
         5'h01: ab = {PF_UART0_RXD, PF_PWM_OUTPUT_3};
         5'h02: ab = {PF_I2C_SCL, PF_CAP0_0};
         5'h03: ab = {PF_I2C_SDA, PF_MAT0_0};
         5'h04: ab = {PF_SPI_SCK, PF_CAP0_1};
         5'h05: ab = {PF_SPI_MISO, PF_MAT0_1};
         5'h06: ab = {PF_SPI_MOSI, PF_CAP0_2};
         5'h07: ab = {PF_SPI_SSEL, PF_PWM_OUTPUT_2};
         5'h08: ab = {PF_UART1_TXD, PF_PWM_OUTPUT_4};
         5'h09: ab = {PF_UART1_RXD, PF_PWM_OUTPUT_6};
         5'h0a: ab = {PF_UART1_RTS, PF_CAP1_0};
         5'h0b: ab = {PF_UART1_CTS, PF_CAP1_1};
         5'h0c: ab = {PF_UART1_DSR, PF_NONE};
         5'h0d: ab = {PF_UART1_DTR, PF_MAT1_1};
         5'h0e: ab = {PF_NONE, PF_EXTERNAL_INT_1};
         5'h0f: ab = {PF_UART1_RI, PF_EXTERNAL_INT_2};
         5'h10: ab = {PF_EXTERNAL_INT_0, PF_MAT0_2};
         5'h11: ab = {PF_CAP1_2, PF_NONE};
         5'h12: ab = {PF_CAP1_3, PF_NONE};
         5'h13: ab = {PF_MAT1_2, PF_NONE};
         5'h14: ab = {PF_MAT1_3, PF_NONE};
         5'h15: ab = {PF_PWM_OUTPUT_5, PF_NONE};
         default: ab = {PF_NONE, PF_NONE};
      endcase
      // gpio and the reserved code 11 both map to none
      if (code == PFS_ALT1) begin
         return ab[2*PF_FW-1:PF_FW];
      end else if (code == PFS_ALT2) begin
         return ab[PF_FW-1:0];
      end
      return PF_NONE;
   endfunction : pfs_route

   // =========================================================================
   // pad and strap synchroniser
   // =========================================================================
   pfs_sync #(
      .W       (PFS_PINS + 1)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({debug_select_i, pin_i}),
      .sync_o  (synced)
   );

   // =========================================================================
   // register file and wishbone slave
   // =========================================================================
   // one registered answer per request, a cycle after it; ack is dropped right after, so a
   // master that holds stb sees exactly one ack per transfer
   always_comb begin
      next_low  = sel_low;
      next_high = sel_high;
      next_dat  = wb_dat_o;
      next_ack  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (next_ack) begin
         if (wb_adr_i == PFS_ADR_LOW) begin
            next_dat = sel_low;
            if (wb_we_i) begin
               next_low = pfs_merge(sel_low, wb_dat_i, wb_sel_i);
            end
         end else if (wb_adr_i == PFS_ADR_HIGH) begin
            next_dat = sel_high;
            if (wb_we_i) begin
               next_high = pfs_merge(sel_high, wb_dat_i, wb_sel_i);
            end
         end else if (wb_adr_i == PFS_ADR_STATUS) begin
            next_dat              = '0;
            next_dat[PFS_DBG_BIT] = debug_mode_o;
         end else begin
            next_dat = '0;  // unmapped: acked, reads zero, writes dropped
         end
      end
      // strap follows the pad only while reset is held, then freezes
      next_dbg = rst_i ? dbg_sync : debug_mode_o;
   end

   // registers only; fields reset to gpio
   always_ff @(posedge clk_i) begin
      debug_mode_o <= next_dbg;
      if (rst_i) begin
         sel_low  <= PFS_SEL_RESET;
         sel_high <= PFS_SEL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         sel_low  <= next_low;
         sel_high <= next_high;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // =========================================================================
   // pin multiplexer
   // =========================================================================
   // outputs are one flop behind the select fields; this costs a cycle of
   // latency on every peripheral path but keeps pad timing clean
   always_comb begin
      logic [1:0]       fld;  // field of the current pin
      logic [PF_FW-1:0] src;  // peripheral routed to it
      logic             dbg;  // pin held by debug
      fld        = PFS_GPIO;
      src        = PF_NONE;
      dbg        = 1'b0;
      next_out   = '0;
      next_oe    = '0;
      next_sense = '{value: PF_IN_IDLE};
      for (int p = 0; p < PFS_PINS; p++) begin
         fld = sel_all[PFS_FLD*p +: PFS_FLD];
         src = pfs_route(5'(p), fld);
         dbg = debug_mode_o && (p >= PFS_DBG_LO);
         if (dbg) begin
            // debug owns the pin whatever its field says; filled in below
            next_out[p] = 1'b0;
            next_oe[p]  = 1'b0;
         end else if (fld == PFS_GPIO) begin
            next_out[p] = gpio_out_i[p];
            next_oe[p]  = gpio_direction_i[p];
         end else if (src == PF_NONE) begin
            // reserved code: pad released so nothing fights
            next_out[p] = 1'b0;
            next_oe[p]  = 1'b0;
         end else begin
            next_out[p] = periph_drive_i.value[src];
            if (src >= PF_OUT_FIRST) begin
               next_oe[p] = 1'b1;
            end else if (src >= PF_IN_FIRST) begin
               next_oe[p] = 1'b0;
            end else begin
               next_oe[p] = periph_drive_i.oe[src];
            end
            next_sense.value[src] = pin_sync[p];
         end
      end
      // debug port takes the upper pins as one slice, no per-pin indexing
      if (debug_mode_o) begin
         next_out[PFS_PINS-1:PFS_DBG_LO] = debug_out_i;
         next_oe[PFS_PINS-1:PFS_DBG_LO]  = debug_oe_i;
      end
   end

   // registers only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_o      <= '0;
         pin_oe_o       <= '0;
         gpio_in_o      <= '0;
         debug_in_o     <= '0;
         periph_sense_o <= '{value: PF_IN_IDLE};
      end else begin
         pin_out_o      <= next_out;
         pin_oe_o       <= next_oe;
         gpio_in_o      <= pin_sync;   // readable whatever the function
         debug_in_o     <= pin_sync[PFS_PINS-1:PFS_DBG_LO];
         periph_sense_o <= next_sense;
      end
   end

   // =========================================================================
   // assertions
   // =========================================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_single_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stayed high");

   ack_next_cycle_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");

   low_write_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_adr_i == PFS_ADR_LOW && wb_sel_i == 4'hf
      |=> sel_low == $past(wb_dat_i) && wb_ack_o)
      else $error("low select write lost");

   high_readback_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
      wb_adr_i == PFS_ADR_HIGH |=> wb_dat_o == $past(sel_high))
      else $error("high select read wrong");

   gpio_dir_a: assert property (
      !debug_mode_o && sel_high[1:0] == PFS_GPIO
      |=> pin_oe_o[16] == $past(gpio_direction_i[16]))
      else $error("gpio direction not applied");

   periph_dir_a: assert property (
      sel_low[3:2] == PFS_ALT1 |=> !pin_oe_o[1] &&
      ($past(sel_low[1:0]) != PFS_ALT1 || pin_oe_o[0]))
      else $error("automatic direction wrong");

   strap_frozen_a: assert property (
      !rst_i ##1 !rst_i |-> $stable(debug_mode_o))
      else $error("debug mode changed outside reset");

   debug_owns_a: assert property (
      debug_mode_o |=> pin_oe_o[31] == $past(debug_oe_i[31]) &&
      pin_out_o[17] == $past(debug_out_i[17]))
      else $error("debug pin not given to debug port");

   scl_route_a: assert property (
      sel_low[5:4] == PFS_ALT1
      |=> periph_sense_o.value[PF_I2C_SCL] == $past(pin_sync[2]))
      else $error("pin 2 not routed to i2c clock");

   cap12_route_a: assert property (
      !debug_mode_o && sel_high[3:2] == PFS_ALT1
      |=> periph_sense_o.value[PF_CAP1_2] == $past(pin_sync[17]))
      else $error("pin 17 not routed to capture");

   reserved_idle_a: assert property (
      sel_low[25:24] == PFS_ALT2 |=> !pin_oe_o[12])
      else $error("reserved code drives pin");

   write_seen_c: cover property (
      wb_ack_o && wb_we_i && wb_adr_i == PFS_ADR_LOW);
   debug_mode_c: cover property (debug_mode_o && pin_oe_o[31]);
   pwm_out_c: cover property (sel_low[1:0] == PFS_ALT2 ##1 pin_oe_o[0]);

endmodule : pfs_pin_mux

/* File: tb/pfs_pin_mux_test.sv */
// self-checking bench for the port 0 pin function select block
`timescale 1ns/1ps
module pfs_pin_mux_test
   import pfs_pkg::*;
;
   // =========================================================================
   // stimulus and observed signals
   // =========================================================================
   logic                         clk_i, rst_i;      // clock, sync reset
   logic                         cyc, stb, we, ack; // bus handshake
   logic [31:0]                  adr, wdat, rdat;   // bus address and data
   logic [31:0]                  dat_o;             // read data from block
   logic [3:0]                   sel;               // byte lanes
   logic [31:0]                  pin, gout, gdir;   // pads and gpio side
   logic [31:0]                  pout, poe, gin;    // pad drive and gpio view
   logic                         dbg_sel, dmode;    // strap and latched mode
   pfs_drive_t                   drv;               // peripheral drive
   pfs_sense_t                   sense;             // peripheral inputs
   logic [PFS_PINS-1:PFS_DBG_LO] dout, doe, din;    // debug port
   int                           failures, checks_done, cycles;
   // pin, code, function; one row per listed alternate, two reserved rows
   localparam logic [12:0] TBL [39] = '{
      {5'h00,2'h1,PF_UART0_TXD}, {5'h00,2'h2,PF_PWM_OUTPUT_1}, {5'h01,2'h1,PF_UART0_RXD},
      {5'h01,2'h2,PF_PWM_OUTPUT_3}, {5'h02,2'h1,PF_I2C_SCL}, {5'h02,2'h2,PF_CAP0_0},
      {5'h03,2'h1,PF_I2C_SDA}, {5'h03,2'h2,PF_MAT0_0}, {5'h04,2'h1,PF_SPI_SCK},
      {5'h04,2'h2,PF_CAP0_1}, {5'h05,2'h1,PF_SPI_MISO}, {5'h05,2'h2,PF_MAT0_1},
      {5'h06,2'h1,PF_SPI_MOSI}, {5'h06,2'h2,PF_CAP0_2}, {5'h07,2'h1,PF_SPI_SSEL},
      {5'h07,2'h2,PF_PWM_OUTPUT_2}, {5'h08,2'h1,PF_UART1_TXD}, {5'h08,2'h2,PF_PWM_OUTPUT_4},
      {5'h09,2'h1,PF_UART1_RXD}, {5'h09,2'h2,PF_PWM_OUTPUT_6}, {5'h0a,2'h1,PF_UART1_RTS},
      {5'h0a,2'h2,PF_CAP1_0}, {5'h0b,2'h1,PF_UART1_CTS}, {5'h0b,2'h2,PF_CAP1_1},
      {5'h0c,2'h1,PF_UART1_DSR}, {5'h0c,2'h2,PF_NONE}, {5'h0d,2'h1,PF_UART1_DTR},
      {5'h0d,2'h2,PF_MAT1_1}, {5'h0e,2'h2,PF_EXTERNAL_INT_1}, {5'h0f,2'h1,PF_UART1_RI},
      {5'h0f,2'h2,PF_EXTERNAL_INT_2}, {5'h10,2'h1,PF_EXTERNAL_INT_0}, {5'h10,2'h2,PF_MAT0_2},
      {5'h11,2'h1,PF_CAP1_2}, {5'h12,2'h1,PF_CAP1_3}, {5'h13,2'h1,PF_MAT1_2},
      {5'h14,2'h1,PF_MAT1_3}, {5'h15,2'h1,PF_PWM_OUTPUT_5}, {5'h00,2'h3,PF_NONE}};

   pfs_pin_mux uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack),
      .wb_dat_o(dat_o), .pin_i(pin), .pin_out_o(pout), .pin_oe_o(poe),
      .debug_select_i(dbg_sel), .gpio_out_i(gout), .gpio_direction_i(gdir),
      .gpio_in_o(gin), .periph_drive_i(drv), .periph_sense_o(sense), .debug_out_i(dout),
      .debug_oe_i(doe), .debug_in_o(din), .debug_mode_o(dmode));

   // =========================================================================
   // clock and hang guard
   // =========================================================================
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // the whole run needs about 1400 cycles; a hang is cut off well past that
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   // =========================================================================
   // shared tasks
   // =========================================================================
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one classic cycle: request held until ack is seen, released at that edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
      @(posedge clk_i);
      while (ack !== 1'b1) begin
         @(posedge clk_i);
      end
      chk("bus ack", 1'b1, ack);
      rdat = dat_o;
      {cyc, stb} <= 2'h0;
   endtask : bus
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      chk("register read", exp, rdat);
   endtask : rd
   task automatic reset_settle;
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : reset_settle
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim

   // =========================================================================
   // test sequence
   // =========================================================================
   initial begin
      logic [5:0]  f;
      logic [4:0]  p;
      logic [31:0] a, v;
      logic        lv;
      {cyc, stb, we, adr, wdat, sel, dbg_sel, dout, doe} <= '0;
      {failures, checks_done, cycles} = '0;
      {rst_i, pin, gout, gdir} <= {1'b1, 32'h1234_8765, 32'h5a5a_0ff0, 32'h0f0f_33cc};
      drv <= '0;
      reset_settle();
      // reset state: every pin is gpio, strap low
      rd(PFS_ADR_LOW, PFS_SEL_RESET);
      rd(PFS_ADR_HIGH, PFS_SEL_RESET);
      chk("debug mode", 1'b0, dmode);
      chk("gpio enable", gdir, poe);
      chk("gpio level", gout, pout);
      chk("gpio input", pin, gin);
      chk("idle inputs", PF_IN_IDLE, sense.value);
      rd(PFS_ADR_STATUS, 32'h0);
      bus(1'b1, 32'he002c010, 32'hffff_ffff, 4'hf);
      rd(32'he002c010, 32'h0);
      // byte lanes land only in their own field groups
      bus(1'b1, PFS_ADR_LOW, 32'hffff_ffff, 4'h2);
      rd(PFS_ADR_LOW, 32'h0000_ff00);
      bus(1'b1, PFS_ADR_HIGH, 32'hffff_ffff, 4'h8);
      rd(PFS_ADR_HIGH, 32'hff00_0000);
      bus(1'b1, PFS_ADR_LOW, 32'h0, 4'hf);
      bus(1'b1, PFS_ADR_HIGH, 32'h0, 4'hf);
      $display("test reset and registers done");
      // every listed code, with gpio direction and peripheral drive flipped per pass
      for (int ps = 0; ps < 2; ps++) begin
         lv = ps[0];
         gdir <= {32{~lv}};
         gout <= {32{~lv}};
         drv.value <= {PF_N{lv}};
         drv.oe <= {PF_N{~lv}};
         for (int i = 0; i < 39; i++) begin
            {p, f} = {TBL[i][12:8], TBL[i][5:0]};
            a = (p < 16) ? PFS_ADR_LOW : PFS_ADR_HIGH;
            v = {30'h0, TBL[i][7:6]} << (2 * (p % 16));
            pin <= ~(32'h1 << p);
            bus(1'b1, a, v, 4'hf);
            rd(a, v);
            repeat (8) @(posedge clk_i);
            // output class drives, input class floats, two-way follows peripheral
            chk("pin enable", (f == PF_NONE) ? 1'b0 : (f >= PF_OUT_FIRST) ? 1'b1 :
                (f >= PF_IN_FIRST) ? 1'b0 : drv.oe[f], poe[p]);
            if (f < PF_IN_FIRST || f >= PF_OUT_FIRST)
               chk("pin level", (f == PF_NONE) ? 1'b0 : drv.value[f], pout[p]);
            if (f != PF_NONE && f < PF_OUT_FIRST)
               chk("function input", 1'b0, sense.value[f]);
            bus(1'b1, a, 32'h0, 4'hf);
         end
      end
      $display("test function codes done");
      // strap high: pins 17..31 stay with the debug port whatever the fields say
      {dbg_sel, dout, doe, pin} <= {1'b1, 15'h2b6d, 15'h51e3, 15'h4c3a, 17'h0};
      reset_settle();
      chk("debug mode", 1'b1, dmode);
      rd(PFS_ADR_STATUS, 32'h1 << PFS_DBG_BIT);
      dbg_sel <= 1'b0;
      bus(1'b1, PFS_ADR_HIGH, 32'h0000_0005, 4'hf);
      rd(PFS_ADR_HIGH, 32'h0000_0005);
      repeat (8) @(posedge clk_i);
      chk("debug mode held", 1'b1, dmode);
      chk("debug enable", doe, poe[31:17]);
      chk("debug level", dout, pout[31:17]);
      chk("debug input", 15'h4c3a, din);
      chk("unfed capture", 1'b1, sense.value[PF_CAP1_2]);
      chk("pin 16 input", 1'b0, sense.value[PF_EXTERNAL_INT_0]);
      $display("test debug takeover done");
      end_sim();
   end
endmodule : pfs_pin_mux_test
